//--- src/dmx_pkg.sv
package dmx_pkg;
  // ==========================================================
  // Geometry of one driver
  localparam int unsigned DOTS_PER_IC     = 160;
  localparam int unsigned COLUMNS_PER_IC  = 20;
  localparam int unsigned ROWS            = 8;
  localparam int unsigned CTRL_SHIFT_W    = 8;
  localparam int unsigned CTRL_WORD_W     = 7;

  // ==========================================================
  // Control shift register and control word fields
  localparam int unsigned WORD_SELECT_POS = 7;
  localparam int unsigned PWM_LSB         = 0;
  localparam int unsigned PWM_W           = 4;
  localparam int unsigned PEAK_LSB        = 4;
  localparam int unsigned PEAK_W          = 2;
  localparam int unsigned AWAKE_POS       = 6;
  localparam int unsigned OUT_MODE_POS    = 0;
  localparam int unsigned PRESCALE_POS    = 1;
  localparam logic [6:0]  CTRL_WORD_RST   = 7'h00;
  localparam logic [7:0]  CTRL_SHIFT_RST  = 8'h00;

  // ==========================================================
  // Refresh timing, in display clock cycles; the prescale values count external oscillator cycles
  localparam int unsigned PRESCALE_DIV    = 8;
  localparam int unsigned REFRESH_CYCLES  = 512;
  localparam int unsigned REFRESH_EXT_DIV = PRESCALE_DIV * REFRESH_CYCLES;
  localparam int unsigned ROW_CYCLES      = REFRESH_CYCLES / ROWS;
  localparam int unsigned ROW_ON_CYCLES   = 60;
  localparam logic [2:0]  PRESCALE_LAST   = 3'h7;

  // ==========================================================
  // Core clock and internal oscillator
  localparam int unsigned CORE_PERIOD_PS  = 8000;
  localparam int unsigned CORE_HZ         = 1000000000 / (CORE_PERIOD_PS / 1000);
  localparam int unsigned INT_OSC_HZ_DFLT = 150000;
  localparam int unsigned SYNC_STAGES     = 3;

  // ==========================================================
  // Buffered serial events
  localparam int unsigned EVT_W           = 3;
  localparam int unsigned EVT_BIT_POS     = 0;
  localparam int unsigned EVT_CTRL_POS    = 1;
  localparam int unsigned EVT_LATCH_POS   = 2;
  localparam int unsigned FIFO_DEPTH_DFLT = 32;

  typedef enum logic [1:0] {
    DMX_IDLE     = 2'b00,
    DMX_LOADING  = 2'b01,
    DMX_WAIT_LOW = 2'b10
  } dmx_load_state_t;
endpackage

//--- src/dmx_fifo.sv
`timescale 1ns/1ps
module dmx_fifo #(
  parameter int unsigned WIDTH = 3,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ==========================================================
  // Parameter check
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("dmx_fifo needs a power of two depth of at least 2");
    end
  endgenerate

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty without a counter
  assign in_ready_o  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

//--- src/dmx_loader.sv
`timescale 1ns/1ps
module dmx_loader
  import dmx_pkg::*;
#(
  parameter int unsigned NUM_IC     = 1,
  parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DFLT,
  parameter int unsigned INT_OSC_HZ = INT_OSC_HZ_DFLT
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          register_select_line_i,
  input  wire logic                          chip_enable_b_i,
  input  wire logic                          serial_clk_i,
  input  wire logic                          serial_data_i,
  input  wire logic                          ext_osc_i,
  input  wire logic                          ext_osc_select_i,
  output logic                               serial_data_o,
  output logic [NUM_IC*DOTS_PER_IC-1:0]      dot_latch_o,
  output logic [NUM_IC*COLUMNS_PER_IC-1:0]   column_drive_o,
  output logic [2:0]                         row_select_o,
  output logic                               row_drive_o,
  output logic [PWM_W-1:0]                   pwm_level_o,
  output logic [PEAK_W-1:0]                  peak_current_o,
  output logic                               awake_o,
  output logic                               passthrough_o,
  output logic                               prescale_o,
  output logic                               display_tick_o,
  output logic                               refresh_done_o,
  output logic                               overrun_o
);
  localparam int unsigned DOT_W   = NUM_IC * DOTS_PER_IC;
  localparam int unsigned COL_W   = NUM_IC * COLUMNS_PER_IC;
  localparam int unsigned INT_DIV = CORE_HZ / INT_OSC_HZ;
  localparam int unsigned PIN_N   = 5;

  // ==========================================================
  // Parameter check
  generate
    if (NUM_IC < 1 || NUM_IC > 2 || INT_DIV < 2 || INT_DIV > 4096) begin : g_bad
      $error("dmx_loader supports one or two drivers and a slow internal oscillator");
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s1;
  logic [PIN_N-1:0] pin_s2;
  logic [PIN_N-1:0] pin_s3;
  logic [PIN_N-1:0] pin_q;
  logic [PIN_N-1:0] pin_prev;
  assign pin_raw = {ext_osc_i, serial_data_i, serial_clk_i, chip_enable_b_i,
                    register_select_line_i};
  // Chip enable idles high, so no stage may show a falling edge at release
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1 <= 5'h02;
      pin_s2 <= 5'h02;
      pin_s3 <= 5'h02;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_q    <= 5'h02;
      pin_prev <= 5'h02;
    end else begin
      pin_q    <= (pin_q & ~(pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
      pin_prev <= pin_q;
    end
  end
  wire logic rs_q      = pin_q[0];
  wire logic ce_b_q    = pin_q[1];
  wire logic sclk_q    = pin_q[2];
  wire logic din_q     = pin_q[3];
  wire logic osc_q     = pin_q[4];
  wire logic sclk_rise = sclk_q && !pin_prev[2];
  wire logic ce_fall   = !ce_b_q && pin_prev[1];
  wire logic osc_rise  = osc_q && !pin_prev[4];

  // ==========================================================
  // Load sequencing
  dmx_load_state_t load_state;
  dmx_load_state_t next_load_state;
  logic            load_is_ctrl;
  logic            evt_valid;
  logic            evt_ready;
  logic [EVT_W-1:0] evt_data;

  always_comb begin
    next_load_state = load_state;
    case (load_state)
      DMX_IDLE: begin
        if (ce_fall) begin
          next_load_state = DMX_LOADING;
        end
      end
      DMX_LOADING: begin
        if (ce_b_q) begin
          next_load_state = DMX_WAIT_LOW;
        end
      end
      DMX_WAIT_LOW: begin
        if (!ce_b_q) begin
          next_load_state = DMX_LOADING;
        end else if (!sclk_q && evt_ready) begin
          next_load_state = DMX_IDLE;
        end
      end
      default: begin
        next_load_state = DMX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_state <= DMX_IDLE;
    end else begin
      load_state <= next_load_state;
    end
  end

  // Register select is taken at the enable falling edge only
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_is_ctrl <= 1'b0;
    end else if (ce_fall) begin
      load_is_ctrl <= rs_q;
    end
  end

  // Shift events while enabled, one latch event once enable is high and clock low
  always_comb begin
    evt_valid = 1'b0;
    evt_data  = {1'b0, load_is_ctrl, din_q};
    if (!ce_b_q && sclk_rise && load_state != DMX_IDLE) begin
      evt_valid = 1'b1;
    end else if (load_state == DMX_WAIT_LOW && ce_b_q && !sclk_q) begin
      evt_valid = 1'b1;
      evt_data  = {1'b1, load_is_ctrl, 1'b0};
    end
  end

  // Pins cannot be stalled, so a full buffer loses the bit and says so
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overrun_o <= 1'b0;
    end else if (evt_valid && !evt_ready) begin
      overrun_o <= 1'b1;
    end else if (ce_fall) begin
      overrun_o <= 1'b0;
    end
  end

  // ==========================================================
  // Event buffer
  logic             buf_valid;
  logic             buf_ready;
  logic [EVT_W-1:0] buf_data;
  logic             commit_hold;

  dmx_fifo #(
    .WIDTH (EVT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (evt_valid),
    .in_ready_o  (evt_ready),
    .in_data_i   (evt_data),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_data)
  );

  // Drain pauses one cycle after each commit so shifts never race the copy
  assign buf_ready = !commit_hold;
  wire logic pop       = buf_valid && buf_ready;
  wire logic pop_latch = buf_data[EVT_LATCH_POS];
  wire logic pop_ctrl  = buf_data[EVT_CTRL_POS];
  wire logic pop_bit   = buf_data[EVT_BIT_POS];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      commit_hold <= 1'b0;
    end else begin
      commit_hold <= pop && pop_latch;
    end
  end

  // ==========================================================
  // Dot shift chain and latches, not reset
  logic [DOT_W-1:0] dot_shift;
  logic [DOT_W-1:0] dot_latch;
  // Driver 2 bit 0 sits at chain position DOTS_PER_IC
  always_ff @(posedge core_clk_i) begin
    if (pop && !pop_latch && !pop_ctrl) begin
      dot_shift <= {dot_shift[DOT_W-2:0], pop_bit};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (pop && pop_latch && !pop_ctrl) begin
      dot_latch <= dot_shift;
    end
  end
  assign dot_latch_o = dot_latch;

  // ==========================================================
  // Control shift register and words
  logic [CTRL_SHIFT_W-1:0] ctrl_shift;
  logic [CTRL_WORD_W-1:0]  bright_word;
  logic [CTRL_WORD_W-1:0]  mode_word;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_shift <= CTRL_SHIFT_RST;
    end else if (pop && !pop_latch && pop_ctrl) begin
      ctrl_shift <= {ctrl_shift[CTRL_SHIFT_W-2:0], pop_bit};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bright_word <= CTRL_WORD_RST;
    end else if (pop && pop_latch && pop_ctrl && !ctrl_shift[WORD_SELECT_POS]) begin
      bright_word <= ctrl_shift[CTRL_WORD_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_word <= CTRL_WORD_RST;
    end else if (pop && pop_latch && pop_ctrl && ctrl_shift[WORD_SELECT_POS]) begin
      mode_word <= ctrl_shift[CTRL_WORD_W-1:0];
    end
  end

  // Each field drives its own function only
  assign pwm_level_o    = bright_word[PWM_LSB +: PWM_W];
  assign peak_current_o = bright_word[PEAK_LSB +: PEAK_W];
  assign awake_o        = bright_word[AWAKE_POS];
  assign passthrough_o  = mode_word[OUT_MODE_POS];
  assign prescale_o     = mode_word[PRESCALE_POS];

  // ==========================================================
  // Serial output
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_data_o <= 1'b0;
    end else if (!load_is_ctrl) begin
      serial_data_o <= dot_shift[DOT_W-1];
    end else if (passthrough_o) begin
      serial_data_o <= din_q;
    end else begin
      serial_data_o <= ctrl_shift[CTRL_SHIFT_W-1];
    end
  end

  // ==========================================================
  // Display clock
  logic [12:0] int_cnt;
  logic [2:0]  pre_cnt;
  // Sleep halts the internal oscillator outright
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_cnt <= '0;
    end else if (!awake_o) begin
      int_cnt <= '0;
    end else if (int_cnt == 13'(INT_DIV - 1)) begin
      int_cnt <= '0;
    end else begin
      int_cnt <= int_cnt + 13'h0001;
    end
  end
  wire logic int_tick = awake_o && int_cnt == 13'(INT_DIV - 1);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_cnt <= '0;
    end else if (!prescale_o) begin
      pre_cnt <= '0;
    end else if (osc_rise) begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end
  wire logic ext_tick = osc_rise && (!prescale_o || pre_cnt == PRESCALE_LAST);
  // Prescaler only shapes the external path
  wire logic tick     = ext_osc_select_i ? (ext_tick && awake_o) : int_tick;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      display_tick_o <= 1'b0;
    end else begin
      display_tick_o <= tick;
    end
  end

  // ==========================================================
  // Refresh scan
  logic [8:0] scan_cnt;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scan_cnt <= '0;
    end else if (tick) begin
      scan_cnt <= scan_cnt + 9'h001;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refresh_done_o <= 1'b0;
    end else begin
      refresh_done_o <= tick && scan_cnt == 9'(REFRESH_CYCLES - 1);
    end
  end
  wire logic [5:0] row_phase = scan_cnt[5:0];
  assign row_select_o = scan_cnt[8:6];
  // Linear on-time is a stand-in; the real curve is not modelled
  function automatic logic [6:0] lit_limit(input logic [PWM_W-1:0] level);
    logic [6:0] lim;
    lim = {1'b0, level, 2'b00} + 7'h04;
    if (lim > 7'(ROW_ON_CYCLES)) begin
      lim = 7'(ROW_ON_CYCLES);
    end
    return lim;
  endfunction
  // Row 0 holds the unused bottom location and is never lit
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_drive_o <= 1'b0;
    end else begin
      row_drive_o <= awake_o && row_select_o != 3'h0 &&
                     {1'b0, row_phase} < lit_limit(pwm_level_o);
    end
  end
  // Column c uses latch locations c*8 .. c*8+7
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < COL_W; c++) begin
      column_drive_o[c] <= awake_o && dot_latch[c*ROWS + int'(row_select_o)];
    end
  end
endmodule

//--- tb/dmx_host_model.sv
`timescale 1ns/1ps
module dmx_host_model #(
  parameter int unsigned H = 12
) (
  input  wire logic core_clk_i,
  output logic      rs_o,
  output logic      ce_b_o,
  output logic      sclk_o,
  output logic      sdata_o
);
  int sent;

  initial begin
    rs_o    = 1'b0;
    ce_b_o  = 1'b1;
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
    sent    = 0;
  end

  // =============================================
  // Frame timing, each level held H core cycles
  task automatic gap();
    repeat (H) @(negedge core_clk_i);
  endtask

  task automatic frame(input logic sel, input logic [159:0] v, input int n);
    rs_o <= sel;
    gap();
    ce_b_o <= 1'b0;
    sent = 0;
    for (int i = n - 1; i >= 0; i--) begin
      sdata_o <= v[i];
      gap();
      sclk_o <= 1'b1;
      sent++;
      gap();
      sclk_o <= 1'b0;
    end
    gap();
    ce_b_o  <= 1'b1;
    // Released data line shows the inverse, not a stale level
    sdata_o <= ~v[0];
    gap();
  endtask

  task automatic dot_load(input logic [159:0] v);
    frame(1'b0, v, 160);
  endtask

  // One driver only, so eight clocks serve either output mode
  task automatic ctrl_load(input logic [7:0] b);
    frame(1'b1, {152'h0, b}, 8);
  endtask
endmodule

//--- tb/dmx_loader_chk.sv
`timescale 1ns/1ps
module dmx_loader_chk
  import dmx_pkg::*;
#(
  parameter int unsigned NUM_IC     = 1,
  parameter int unsigned INT_OSC_HZ = INT_OSC_HZ_DFLT
) (
  input wire logic                          core_clk_i,
  input wire logic                          rst_b_i,
  input wire logic                          chip_enable_b_i,
  input wire logic                          serial_clk_i,
  input wire logic                          ext_osc_select_i,
  input wire logic [NUM_IC*DOTS_PER_IC-1:0] dot_latch_o,
  input wire logic [2:0]                    row_select_o,
  input wire logic                          row_drive_o,
  input wire logic [PWM_W-1:0]              pwm_level_o,
  input wire logic [PEAK_W-1:0]             peak_current_o,
  input wire logic                          awake_o,
  input wire logic                          passthrough_o,
  input wire logic                          prescale_o,
  input wire logic                          display_tick_o,
  input wire logic                          refresh_done_o
);
  localparam int unsigned DIV = CORE_HZ / INT_OSC_HZ;
  logic [9:0]  ref_cnt;
  logic        ref_arm;
  logic [15:0] gap;
  logic        gap_ok;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // =============================================
  // Tick counters
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_cnt <= 10'h000;
      ref_arm <= 1'b0;
    end else if (refresh_done_o) begin
      ref_cnt <= 10'h000;
      ref_arm <= 1'b1;
    end else if (display_tick_o) begin
      ref_cnt <= ref_cnt + 10'h001;
    end
  end

  // Spacing is trusted only after a clean tick on the internal source
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap    <= 16'h0000;
      gap_ok <= 1'b0;
    end else begin
      gap <= display_tick_o ? 16'h0000 : gap + 16'h0001;
      if (!awake_o || ext_osc_select_i) begin
        gap_ok <= 1'b0;
      end else if (display_tick_o) begin
        gap_ok <= 1'b1;
      end
    end
  end

  // =============================================
  // Properties
  ctrl_rst_a: assert property ($rose(rst_b_i) |-> !awake_o && pwm_level_o == 4'h0
    && peak_current_o == 2'h0 && !passthrough_o && !prescale_o)
    else $error("control words not cleared by reset");
  word0_hold_a: assert property ($changed({pwm_level_o, peak_current_o, awake_o})
    |-> chip_enable_b_i && !serial_clk_i) else $error("word 0 changed outside latch");
  word1_hold_a: assert property ($changed({passthrough_o, prescale_o})
    |-> chip_enable_b_i && !serial_clk_i) else $error("word 1 changed outside latch");
  word_excl_a: assert property (!($changed({pwm_level_o, peak_current_o, awake_o})
    && $changed({passthrough_o, prescale_o}))) else $error("both words changed at once");
  dot_hold_a: assert property ($changed(dot_latch_o) |-> chip_enable_b_i && !serial_clk_i)
    else $error("dot latch changed outside latch");
  sleep_stop_a: assert property (!awake_o && !$past(awake_o) && !$past(awake_o, 2)
    |-> !display_tick_o && !row_drive_o) else $error("activity while asleep");
  refresh_len_a: assert property (refresh_done_o && ref_arm
    |-> ref_cnt + display_tick_o == REFRESH_CYCLES) else $error("refresh length wrong");
  tick_int_a: assert property (display_tick_o && gap_ok |-> gap == DIV - 1)
    else $error("internal tick spacing wrong");
  row_zero_a: assert property (row_drive_o |-> row_select_o != 3'h0
    || $past(row_select_o) != 3'h0) else $error("bottom row driven");

  refresh_c: cover property (refresh_done_o);
  latch_c: cover property ($changed(dot_latch_o));
  pass_c: cover property ($rose(passthrough_o));
endmodule

bind dmx_loader dmx_loader_chk #(.NUM_IC(NUM_IC), .INT_OSC_HZ(INT_OSC_HZ)) u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .chip_enable_b_i(chip_enable_b_i),
  .serial_clk_i(serial_clk_i), .ext_osc_select_i(ext_osc_select_i),
  .dot_latch_o(dot_latch_o), .row_select_o(row_select_o), .row_drive_o(row_drive_o),
  .pwm_level_o(pwm_level_o), .peak_current_o(peak_current_o), .awake_o(awake_o),
  .passthrough_o(passthrough_o), .prescale_o(prescale_o),
  .display_tick_o(display_tick_o), .refresh_done_o(refresh_done_o)
);

//--- tb/test_serial_dot_matrix_loader.sv
`timescale 1ns/1ps
module test_serial_dot_matrix_loader;
  import dmx_pkg::*;
  localparam int INT_HZ  = 12500000;
  localparam int INT_DIV = CORE_HZ / INT_HZ;
  localparam int OSC_CYC = 10;
  logic         core_clk, rst_b, ext_osc, ext_sel, rs, ce_b, sclk, din, dout;
  logic         awake, pt, pre, tick, done, ovr, rdrv;
  logic [159:0] latch, v1, v2;
  logic [19:0]  cols;
  logic [2:0]   row;
  logic [3:0]   pwm;
  logic [1:0]   peak;
  logic [7:0]   last;
  logic [6:0]   w0e, w1e;
  int           failures, n_tests;

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  // Oscillator pin moves on falling edges like every other input
  initial ext_osc = 1'b0;
  always begin
    repeat (OSC_CYC / 2) @(negedge core_clk);
    ext_osc <= ~ext_osc;
  end

  dmx_loader #(.NUM_IC(1), .INT_OSC_HZ(INT_HZ)) u_dut (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .register_select_line_i(rs),
    .chip_enable_b_i(ce_b), .serial_clk_i(sclk), .serial_data_i(din),
    .ext_osc_i(ext_osc), .ext_osc_select_i(ext_sel), .serial_data_o(dout),
    .dot_latch_o(latch), .column_drive_o(cols), .row_select_o(row), .row_drive_o(rdrv),
    .pwm_level_o(pwm), .peak_current_o(peak), .awake_o(awake), .passthrough_o(pt),
    .prescale_o(pre), .display_tick_o(tick), .refresh_done_o(done), .overrun_o(ovr)
  );

  dmx_host_model #(.H(12)) u_host (
    .core_clk_i(core_clk), .rs_o(rs), .ce_b_o(ce_b), .sclk_o(sclk), .sdata_o(din)
  );

  // =============================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Column c shows latch location c*8+row while awake
  function automatic logic [19:0] col_exp(input logic [159:0] v, input logic [2:0] r,
                                          input logic awk);
    logic [19:0] e;
    for (int c = 0; c < COLUMNS_PER_IC; c++) begin
      e[c] = awk && v[c * ROWS + r];
    end
    return e;
  endfunction

  // Columns are registered from the row seen one cycle earlier
  task automatic cols_chk(input logic [159:0] v);
    logic [2:0] r;
    r = row;
    cyc(1);
    check(cols, col_exp(v, r, w0e[6]));
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic ctrl(input logic [7:0] b);
    fork
      u_host.ctrl_load(b);
      begin
        wait (u_host.sent == 4);
        cyc(10);
        check({awake, peak, pwm, pre, pt}, {w0e, w1e[1:0]});
        check(dout, w1e[0] ? b[4] : last[3]);
      end
    join
    last = b;
    if (b[7]) w1e = b[6:0];
    else w0e = b[6:0];
    cyc(4);
    check({awake, peak, pwm}, w0e);
    check({pre, pt}, w1e[1:0]);
  endtask

  task automatic dot(input logic [159:0] v, input logic [159:0] prev, input logic mid);
    fork
      u_host.dot_load(v);
      if (mid) begin
        wait (u_host.sent == 5);
        cyc(10);
        check(latch, prev);
        check(dout, prev[154]);
      end
    join
    cyc(4);
    check(latch, v);
    cols_chk(v);
  endtask

  task automatic ticks(input int n, input int e);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (tick === 1'b1) k++;
    end
    check(k inside {[e - 1:e + 1]}, 1'b1);
  endtask

  // =============================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    ext_sel = 1'b0;
    failures = 0;
    n_tests = 0;
    last = 8'h00;
    w0e = 7'h00;
    w1e = 7'h00;
    void'($urandom(32'hff3bb950));
    cyc(6);
    check(dout, 1'b0);
    rst_b = 1'b1;
    cyc(2);
    check({awake, peak, pwm, pre, pt, rdrv, ovr}, 11'h000);
    $display("reset test done");
    repeat (3) ctrl({2'b01, 6'($urandom)});
    $display("word 0 test done");
    v1 = {$urandom, $urandom, $urandom, $urandom, $urandom};
    dot(v1, v1, 1'b0);
    ctrl(8'h83);
    ctrl({2'b01, 6'($urandom)});
    v2 = {$urandom, $urandom, $urandom, $urandom, $urandom};
    dot(v2, v1, 1'b1);
    $display("dot test done");
    ticks(200, 200 / INT_DIV);
    ext_sel = 1'b1;
    cyc(100);
    ticks(800, 800 / (OSC_CYC * PRESCALE_DIV));
    ctrl(8'h81);
    cyc(100);
    ticks(800, 800 / OSC_CYC);
    cyc(11000);
    $display("clock test done");
    ctrl(8'h0f);
    ticks(200, 0);
    check(latch, v2);
    cols_chk(v2);
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(2);
    check({awake, peak, pwm, pre, pt, ovr}, 10'h000);
    check(latch, v2);
    $display("sleep and reset test done");
    wrap_up();
  end

  initial begin
    cyc(40000);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
